// >>> design/capsd_scan.sv
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module capsd_scan #(
  parameter int NSENS = 8,
  parameter int SW    = 3
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             comparator_below,
  output logic      [NSENS-1:0] precharge_switch,
  output logic      [NSENS-1:0] bus_connect_switch,
  output logic                  modulation_current_dac_on,
  output logic      [7:0]       modulation_current_dac,
  output logic                  compensation_current_dac_on,
  output logic      [6:0]       compensation_current_dac
);
  import capsd_pkg::*;

  typedef struct packed {
    capsd_state_t st;
    logic         dual;
    logic         comp_en;
    logic [3:0]   res;
    logic [SW-1:0] sel;
    logic [7:0]   swdiv;
    logic [7:0]   moddac;
    logic [6:0]   compdac;
    logic [7:0]   divcnt;
    logic [1:0]   phase;      // 0 pre, 1 gap, 2 bus, 3 gap
    logic [16:0]  win;
    logic [15:0]  acc;
    logic         bit_on;
    logic         done;
    logic         wr_pend;
    logic         rd_pend;
    logic [7:0]   addr;
    logic [31:0]  rdata;
    logic         rd_raw;
    logic [15:0]  raw_last;
  } capsd_reg_t;

  capsd_reg_t r;
  capsd_reg_t next_r;
  logic [15:0] mem_rd;
  logic        mem_we;

  function automatic logic [16:0] full_range(input logic [3:0] res);
    // Five-bit shift amount so a 16-bit resolution does not wrap to zero
    full_range = (17'h00001 << ({1'b0, res} + 5'd1)) - 17'h00001;
  endfunction

  capsd_raw_mem #(.DEPTH(NSENS), .AW(SW)) u_mem (
    .hclk    (hclk),
    .wr_addr (r.sel),
    .wr_en   (mem_we),
    .wr_data (r.acc),
    .rd_addr (haddr[SW+1:2]),
    .rd_data (mem_rd)
  );

  assign mem_we = (r.st == CAPSD_DONE);

  always_comb begin
    next_r = r;
    next_r.rd_raw = 1'b0;
    // Address phase capture; writes complete in the following data phase
    if (hsel && hready && htrans[1]) begin
      next_r.addr    = haddr[7:0];
      next_r.wr_pend = hwrite;
      next_r.rd_pend = !hwrite;
    end else if (hready) begin
      next_r.wr_pend = 1'b0;
      next_r.rd_pend = 1'b0;
    end
    if (r.wr_pend) begin
      case (r.addr)
        CAPSD_CTRL_OFF: begin
          // Mode and pin are locked while a scan runs so the compensation DAC stays steady
          if (r.st == CAPSD_IDLE) begin
            next_r.dual    = hwdata[CAPSD_CTRL_DUAL_BIT];
            next_r.comp_en = hwdata[CAPSD_CTRL_COMP_BIT];
            next_r.res     = (hwdata[CAPSD_CTRL_RES_LSB +: 4] < CAPSD_RES_MIN - 4'd1)
                             ? CAPSD_RES_MIN - 4'd1 : hwdata[CAPSD_CTRL_RES_LSB +: 4];
            next_r.sel     = hwdata[CAPSD_CTRL_SEL_LSB +: SW];
            if (hwdata[CAPSD_CTRL_START_BIT]) begin
              next_r.st     = CAPSD_SCAN;
              next_r.acc    = 16'h0000;
              next_r.win    = full_range(next_r.res);
              next_r.divcnt = 8'h00;
              next_r.phase  = 2'd0;
              next_r.done   = 1'b0;
            end
          end
        end
        CAPSD_SWDIV_OFF: begin
          if (r.st == CAPSD_IDLE) next_r.swdiv = hwdata[7:0];
        end
        CAPSD_DAC_OFF: begin
          if (r.st == CAPSD_IDLE) begin
            next_r.moddac  = hwdata[CAPSD_DAC_MOD_LSB +: 8];
            next_r.compdac = hwdata[CAPSD_DAC_COMP_LSB +: 7];
          end
        end
        default: ;
      endcase
    end
    // Memory read is launched in the address phase so its word stands in the data phase
    if (hsel && hready && htrans[1] && !hwrite && haddr[7:0] >= CAPSD_RAW_BASE_OFF) begin
      next_r.rd_raw = 1'b1;
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        CAPSD_CTRL_OFF: begin
          next_r.rdata = CAPSD_RDATA_RST;
          next_r.rdata[CAPSD_CTRL_SEL_LSB +: SW] = r.sel;
          next_r.rdata[CAPSD_CTRL_RES_LSB +: 4]  = r.res;
          next_r.rdata[CAPSD_CTRL_COMP_BIT]      = r.comp_en;
          next_r.rdata[CAPSD_CTRL_DUAL_BIT]      = r.dual;
        end
        CAPSD_SWDIV_OFF: next_r.rdata = {24'h000000, r.swdiv};
        CAPSD_DAC_OFF: next_r.rdata = {17'h00000, r.compdac, r.moddac};
        CAPSD_STATUS_OFF: next_r.rdata = {r.raw_last, 14'h0000, r.st == CAPSD_SCAN, r.done};
        default: next_r.rdata = CAPSD_RDATA_RST;
      endcase
    end
    case (r.st)
      CAPSD_IDLE: ;
      CAPSD_SCAN: begin
        // four phases, two gaps keep the switches from overlapping
        if (r.divcnt == r.swdiv) begin
          next_r.divcnt = 8'h00;
          next_r.phase  = r.phase + 2'd1;
        end else begin
          next_r.divcnt = r.divcnt + 8'h01;
        end
        next_r.bit_on = comparator_below;
        if (r.bit_on) next_r.acc = r.acc + 16'h0001;
        next_r.win = r.win - 17'h00001;
        if (r.win == 17'h00001) next_r.st = CAPSD_DONE;
      end
      CAPSD_DONE: begin
        next_r.st       = CAPSD_IDLE;
        next_r.done     = 1'b1;
        next_r.raw_last = r.acc;
        next_r.bit_on   = 1'b0;
      end
      default: next_r.st = CAPSD_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r         <= '0;
      r.st      <= CAPSD_IDLE;
      r.res     <= CAPSD_RES_RST - 4'd1;
      r.swdiv   <= CAPSD_SWDIV_RST;
      r.moddac  <= CAPSD_MODDAC_RST;
      r.compdac <= CAPSD_COMPDAC_RST;
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r.rd_raw ? {16'h0000, mem_rd} : r.rdata;

  always_comb begin
    precharge_switch   = '0;
    bus_connect_switch = '0;
    if (r.st == CAPSD_SCAN) begin
      precharge_switch[r.sel]   = (r.phase == 2'd0);
      bus_connect_switch[r.sel] = (r.phase == 2'd2);
    end
  end

  // on/off gate only; magnitude is the code. 7-bit codes in dual mode
  assign modulation_current_dac_on   = (r.st == CAPSD_SCAN) && r.bit_on;
  assign modulation_current_dac      = r.dual ? {1'b0, r.moddac[6:0]} : r.moddac;
  assign compensation_current_dac_on = (r.st == CAPSD_SCAN) && r.dual && r.comp_en;
  assign compensation_current_dac    = r.dual ? r.compdac : 7'h00;

  no_overlap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (precharge_switch & bus_connect_switch) == '0) else $error("switches overlap");
  one_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot0(precharge_switch | bus_connect_switch)) else $error("multiple pins");
  dac_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == CAPSD_SCAN && comparator_below && r.win != 17'h00001)
    |=> modulation_current_dac_on)
    else $error("dac not on");
  acc_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == CAPSD_IDLE && $past(r.st) == CAPSD_IDLE && r.wr_pend && r.addr == CAPSD_CTRL_OFF
     && hwdata[0]) |=> r.acc == 16'h0000) else $error("acc not cleared");
  acc_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == CAPSD_SCAN && r.bit_on) |=> r.acc == $past(r.acc) + 16'h0001)
    else $error("acc missed bit");
  comp_steady_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == CAPSD_SCAN && $past(r.st) == CAPSD_SCAN) |-> $stable(compensation_current_dac_on))
    else $error("comp dac toggled");
  res_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.res >= CAPSD_RES_MIN - 4'd1 && r.res <= CAPSD_RES_MAX) else $error("bad res");
  raw_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.st == CAPSD_DONE |-> {1'b0, r.acc} <= full_range(r.res)) else $error("over range");
  dual_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.dual |-> modulation_current_dac[7] == 1'b0) else $error("code too wide");
endmodule
`default_nettype wire

// >>> design/capsd_pkg.sv
// Functional notes
// - Convert each sensor pin, keep result
// - Two equal, opposite, non-overlapping switch clocks
// - Modulation DAC gated on/off, 8-bit code
// - Comparator decides DAC on or off
// - Duty cycle balances sensor current
// - Accumulate bit stream into raw count
// - Resolution selectable nine to sixteen bits
// - Full range is two^N minus one
// - Single-DAC and dual-DAC modes
// - Compensation DAC steady for whole scan
// - Dual mode uses 7-bit DAC codes
package capsd_pkg;
  localparam logic [7:0] CAPSD_CTRL_OFF     = 8'h00;
  localparam logic [7:0] CAPSD_SWDIV_OFF    = 8'h04;
  localparam logic [7:0] CAPSD_DAC_OFF      = 8'h08;
  localparam logic [7:0] CAPSD_STATUS_OFF   = 8'h0C;
  localparam logic [7:0] CAPSD_RAW_BASE_OFF = 8'h40;
  // CTRL fields
  localparam int CAPSD_CTRL_START_BIT = 0;
  localparam int CAPSD_CTRL_DUAL_BIT  = 1;
  localparam int CAPSD_CTRL_COMP_BIT  = 2;
  localparam int CAPSD_CTRL_RES_LSB   = 4;
  localparam int CAPSD_CTRL_SEL_LSB   = 8;
  // DAC fields
  localparam int CAPSD_DAC_MOD_LSB  = 0;
  localparam int CAPSD_DAC_COMP_LSB = 8;
  localparam logic [3:0]  CAPSD_RES_MIN   = 4'd9;
  localparam logic [3:0]  CAPSD_RES_MAX   = 4'd15; // Field code 15 plus 1 = 16 bits
  localparam logic [3:0]  CAPSD_RES_RST   = 4'd9;
  localparam logic [7:0]  CAPSD_SWDIV_RST = 8'h04;
  localparam logic [7:0]  CAPSD_MODDAC_RST = 8'h40;
  localparam logic [6:0]  CAPSD_COMPDAC_RST = 7'h20;
  localparam logic [31:0] CAPSD_RDATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    CAPSD_IDLE = 2'b00,
    CAPSD_SCAN = 2'b01,
    CAPSD_DONE = 2'b11
  } capsd_state_t;
endpackage

// >>> design/capsd_raw_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Raw count store, one word per sensor, registered read
module capsd_raw_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          hclk,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic          wr_en,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_data
);
  logic [15:0] mem [DEPTH];
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// >>> sim/capsd_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module capsd_pad_model #(
  parameter int N = 8
) (
  input  wire logic         hclk,
  input  wire logic [N-1:0] bus_connect_switch,
  input  wire logic         modulation_current_dac_on,
  output logic              comparator_below
);
  int level = 0;
  // A pad only sinks charge while its switch ties it to the sense bus
  always @(posedge hclk)
    level <= level + (modulation_current_dac_on ? 3 : 0) - ((|bus_connect_switch) ? 2 : 0);
  assign comparator_below = level < 0;
endmodule
`default_nettype wire

// >>> sim/test_capacitance_sigma_delta_scan.sv
`timescale 1ns/1ps
`default_nettype none
module test_capacitance_sigma_delta_scan;
  import capsd_pkg::*;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, cmp_below, mdac_on, cdac_on;
  logic [7:0]  mdac, pre_sw, bus_sw;
  logic [6:0]  cdac;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          ones, pre_hi, sel;
  bit          scan_on = 0;
  bit          dual, comp;
  capsd_scan #(.NSENS(8), .SW(3)) capsd_scan_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .comparator_below(cmp_below), .precharge_switch(pre_sw),
    .bus_connect_switch(bus_sw), .modulation_current_dac_on(mdac_on),
    .modulation_current_dac(mdac), .compensation_current_dac_on(cdac_on),
    .compensation_current_dac(cdac));
  capsd_pad_model #(.N(8)) capsd_pad_model_i (.hclk(hclk), .bus_connect_switch(bus_sw),
    .modulation_current_dac_on(mdac_on), .comparator_below(cmp_below));
  initial forever #4 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bail;
    n_errors++;
    final_report();
  endtask
  task automatic wait_rdy;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
      bail();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Switch checks run every cycle from the clock after the first scan cycle until done is read; DAC code checks skip non-overlap gaps, where no switch is on
  always @(negedge hclk) begin
    if (scan_on) begin
      ones += mdac_on;
      pre_hi += pre_sw[sel];
      chk({pre_sw & bus_sw, (pre_sw | bus_sw) & ~(8'h01 << sel)}, 32'h0);
      if (|(pre_sw | bus_sw))
        chk({cdac_on, mdac}, {dual & comp, dual ? 8'h45 : 8'hC5});
      if (dual && |(pre_sw | bus_sw))
        chk(cdac, 7'h33);
    end
  end
  task automatic scan(input int res, input int s, input bit d, input bit c);
    int n = 0;
    int nb;
    int r;
    sel = s;
    dual = d;
    comp = c;
    ones = 0;
    pre_hi = 0;
    nb = res < 8 ? 9 : res + 1;
    ahb(1'b1, CAPSD_CTRL_OFF, (s << 8) | (res << 4) | (c << 2) | (d << 1) | 1);
    @(posedge hclk);
    scan_on = 1;
    ahb(1'b1, CAPSD_SWDIV_OFF, 32'h7);
    do begin
      ahb(1'b0, CAPSD_STATUS_OFF, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 2000);
    scan_on = 0;
    if (rd[0] !== 1'b1)
      bail();
    r = rd[31:16];
    chk(r > 0 && r <= (1 << nb) - 1 && (ones - r) inside {[-2:2]}, 1);
    rchk(CAPSD_RAW_BASE_OFF + 4 * s, r);
    rchk(CAPSD_SWDIV_OFF, CAPSD_SWDIV_RST);
    chk(pre_hi > 0, 1);
    $display("scan of sensor %0d at %0d bits finished", s, nb);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(CAPSD_SWDIV_OFF, CAPSD_SWDIV_RST);
    rchk(CAPSD_DAC_OFF, {CAPSD_COMPDAC_RST, CAPSD_MODDAC_RST});
    chk({pre_sw, bus_sw, mdac_on, cdac_on, hresp}, 32'h0);
    ahb(1'b1, 32'h30, 32'hFF);
    rchk(32'h30, 32'h0);
    ahb(1'b1, CAPSD_DAC_OFF, 32'h33C5);
    rchk(CAPSD_DAC_OFF, 32'h33C5);
    $display("register test finished");
    scan(8, 3, 1'b0, 1'b0);
    scan(2, 7, 1'b1, 1'b1);
    scan(9, 0, 1'b1, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
